// [hw/rshd_status_display.sv]
// running status word, keypad menu walk and four-digit monitor drive
`timescale 1ns/1ps
`include "rshd_regs.svh"
// Function
// - sixteen-bit status word, one flag per bit with bits 14-13 held at zero, refreshed every cycle.
// - bit 15 high while a parameter write is in progress.
// - bit 12 high while the link holds run and frequency authority.
// - bit 11 high while an alarm is active.
// - bit 3 high while the output stage is shut off.
// - bit 8 high under current limiting.
// - bit 7 high under voltage limiting.
// - bit 6 high under torque limiting.
// - bit 5 high while bus voltage is above the undervoltage level.
// - bit 1 high in reverse running; bit 9 high while ramping up.
// - bit 0 high in forward running only.
// - four nibbles to four digits, bits 15-12 on the left.
// - nibbles ten to fifteen shown as A b C d E F.
// - start in running mode; enter opens the function menu.
// - I/O check menu offered only when menu scope equals two.
// - up or down toggles segment and hex view on terminal items.
// - program key leaves data for list, then list for menu.
module rshd_status_display (
	input wire logic clk_i,
	input wire logic resetn_i,
	input rshd_pkg::rshd_flags_type flags_i,
	input rshd_pkg::rshd_keys_type keys_i,
	input wire logic [1:0] menu_scope_setting_i,
	input wire logic [15:0] io_terminal_i,
	input wire logic [15:0] io_link_terminal_i,
	output logic [15:0] status_word_o,
	output logic [6:0] display_digit_high_o,
	output logic [6:0] display_digit_upper_mid_o,
	output logic [6:0] display_digit_lower_mid_o,
	output logic [6:0] display_digit_low_o,
	output logic programming_mode_o,
	output logic hex_view_o
);
	import rshd_pkg::*;

	// ***********************************
	// status word
	// ***********************************
	logic [15:0] status_d;
	logic [15:0] status_q;
	always_comb begin
		status_d = `RSHD_STATUS_RST;
		status_d[`RSHD_BIT_BSY] = flags_i.write_busy;
		status_d[`RSHD_BIT_RSV_HI] = 1'b0;
		status_d[`RSHD_BIT_RSV_LO] = 1'b0;
		status_d[`RSHD_BIT_LNK] = flags_i.link_command_enable_flag;
		status_d[`RSHD_BIT_FLT] = flags_i.fault_active_flag;
		status_d[`RSHD_BIT_RDN] = flags_i.ramp_down_flag;
		status_d[`RSHD_BIT_RUP] = flags_i.ramp_up_flag;
		status_d[`RSHD_BIT_CUR] = flags_i.current_limit_flag;
		status_d[`RSHD_BIT_VLT] = flags_i.voltage_limit_flag;
		status_d[`RSHD_BIT_TQL] = flags_i.torque_limit_flag;
		status_d[`RSHD_BIT_BUS] = flags_i.bus_voltage_ok_flag;
		status_d[`RSHD_BIT_BRK] = flags_i.braking_flag;
		status_d[`RSHD_BIT_OFF] = flags_i.output_off_flag;
		status_d[`RSHD_BIT_DCB] = flags_i.dc_injection_flag;
		status_d[`RSHD_BIT_REV] = flags_i.reverse_run_flag;
		// forward and reverse both asserted is a drive fault; forward is dropped
		status_d[`RSHD_BIT_FWD] = flags_i.forward_run_flag & ~flags_i.reverse_run_flag;
	end
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			status_q <= `RSHD_STATUS_RST;
		end else begin
			status_q <= status_d;
		end
	end

	// ***********************************
	// keypad
	// ***********************************
	rshd_keys_type press;
	rshd_key_sync u_keys (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.keys_i(keys_i),
		.press_o(press)
	);

	// ***********************************
	// menu walk
	// ***********************************
	rshd_state_type state_d;
	rshd_state_type state_q;
	logic [2:0] menu_d;
	logic [2:0] menu_q;
	logic [4:0] item_d;
	logic [4:0] item_q;
	logic hex_d;
	logic hex_q;
	wire io_hidden = menu_scope_setting_i != `RSHD_SCOPE_FULL;
	wire [2:0] menu_inc = menu_q + 3'h1;
	wire [2:0] menu_dec = menu_q - 3'h1;
	wire [2:0] menu_next = (io_hidden && menu_inc == `RSHD_MENU_IO) ? menu_inc + 3'h1 : menu_inc;
	wire [2:0] menu_prev = (io_hidden && menu_dec == `RSHD_MENU_IO) ? menu_dec - 3'h1 : menu_dec;
	wire on_io = menu_q == `RSHD_MENU_IO;
	wire term_item = on_io && (item_q == `RSHD_ITEM_TERM || item_q == `RSHD_ITEM_LINK);
	// a press of two keys in one cycle: program wins, then enter, then arrows
	always_comb begin
		state_d = state_q;
		menu_d = menu_q;
		item_d = item_q;
		hex_d = hex_q;
		case (state_q)
			RSHD_RUN: begin
				if (press.enter) begin
					state_d = RSHD_MENU;
					menu_d = `RSHD_MENU_RST;
				end
			end
			RSHD_MENU: begin
				if (press.prog) begin
					state_d = RSHD_RUN;
				end else if (press.enter) begin
					state_d = RSHD_LIST;
					item_d = `RSHD_ITEM_RST;
				end else if (press.up) begin
					menu_d = menu_next;
				end else if (press.down) begin
					menu_d = menu_prev;
				end else if (io_hidden && on_io) begin
					// scope narrowed while parked on the hidden entry
					menu_d = `RSHD_MENU_RST;
				end
			end
			RSHD_LIST: begin
				if (press.prog) begin
					state_d = RSHD_MENU;
				end else if (press.enter) begin
					state_d = RSHD_DATA;
					hex_d = 1'b0;
				end else if (press.up) begin
					item_d = item_q + 5'h01;
				end else if (press.down) begin
					item_d = item_q - 5'h01;
				end
			end
			RSHD_DATA: begin
				if (press.prog) begin
					state_d = RSHD_LIST;
				end else if ((press.up || press.down) && term_item) begin
					hex_d = ~hex_q;
				end
			end
			default: begin
				state_d = RSHD_RUN;
			end
		endcase
	end
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_q <= RSHD_RUN;
			menu_q <= `RSHD_MENU_RST;
			item_q <= `RSHD_ITEM_RST;
			hex_q <= 1'b0;
		end else begin
			state_q <= state_d;
			menu_q <= menu_d;
			item_q <= item_d;
			hex_q <= hex_d;
		end
	end

	// ***********************************
	// digit selection
	// ***********************************
	wire [15:0] term_word = (item_q == `RSHD_ITEM_LINK) ? io_link_terminal_i : io_terminal_i;
	wire show_status = state_q == RSHD_RUN ||
		(state_q == RSHD_DATA && menu_q == `RSHD_MENU_MON && item_q == `RSHD_ITEM_STATUS);
	wire show_term = state_q == RSHD_DATA && term_item;
	wire show_raw = show_term && !hex_q;
	// all terminals open lights segment g everywhere, so a dark panel means no power
	wire term_quiet = term_word == 16'h0000;
	rshd_glyph_type glyph [4];
	logic [6:0] dec_seg [4];
	logic [6:0] raw_seg [4];
	logic [6:0] pick_seg [4];
	logic [6:0] digit_q [4];
	genvar d;
	generate
		for (d = 0; d < 4; d++) begin : g_digit
			// digit 3 is the leftmost and carries bits 15-12
			wire [3:0] stat_nib = status_q[d*4 +: 4];
			wire [3:0] term_nib = term_word[d*4 +: 4];
			wire [4:0] list_gly = (d == 3) ? {2'b00, menu_q} :
				(d == 2) ? `RSHD_GLY_DASH :
				(d == 1) ? {4'h0, item_q[4]} : {1'b0, item_q[3:0]};
			wire [4:0] menu_gly = (d == 3) ? {2'b00, menu_q} : `RSHD_GLY_DASH;
			assign glyph[d] = show_status ? {1'b0, stat_nib} :
				show_term ? {1'b0, term_nib} :
				(state_q == RSHD_MENU) ? menu_gly :
				(state_q == RSHD_LIST) ? list_gly : `RSHD_GLY_DASH;
			rshd_seg_decode u_dec (
				.glyph_i(glyph[d]),
				.seg_o(dec_seg[d])
			);
			// segment view: one terminal per segment a to d of each digit
			assign raw_seg[d] = term_quiet ? `RSHD_SEG_DASH : {3'b000, term_nib};
			assign pick_seg[d] = show_raw ? raw_seg[d] : dec_seg[d];
			always_ff @(posedge clk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					digit_q[d] <= `RSHD_SEG_OFF;
				end else begin
					digit_q[d] <= pick_seg[d];
				end
			end
		end
	endgenerate
	assign display_digit_high_o = digit_q[3];
	assign display_digit_upper_mid_o = digit_q[2];
	assign display_digit_lower_mid_o = digit_q[1];
	assign display_digit_low_o = digit_q[0];
	assign status_word_o = status_q;
	assign programming_mode_o = state_q != RSHD_RUN;
	assign hex_view_o = hex_q;

	// ***********************************
	// assertions
	// ***********************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	AST_WORD_FOLLOWS: assert property (##1 status_q == $past(status_d)) else $error("status word lags its flags");
	AST_BUSY_BIT: assert property (flags_i.write_busy |=> status_q[15]) else $error("busy bit missing");
	AST_RESERVED_ZERO: assert property (status_q[14:13] == 2'b00) else $error("reserved bits set");
	AST_LINK_FAULT: assert property (##1 status_q[12:11] ==
		$past({flags_i.link_command_enable_flag, flags_i.fault_active_flag}))
		else $error("link or alarm bit wrong");
	AST_LIMIT_BITS: assert property (##1 {status_q[8], status_q[7], status_q[6], status_q[3]} ==
		$past({flags_i.current_limit_flag, flags_i.voltage_limit_flag,
		flags_i.torque_limit_flag, flags_i.output_off_flag}))
		else $error("limit or shutoff bit wrong");
	AST_FWD_EXCLUSIVE: assert property (status_q[0] |-> !status_q[1]) else $error("forward with reverse");
	AST_RUN_TO_MENU: assert property (state_q == RSHD_RUN && press.enter |=>
		state_q == RSHD_MENU && menu_q == 3'h0) else $error("enter ignored in run mode");
	AST_IO_HIDDEN: assert property (io_hidden && state_q == RSHD_MENU && !on_io |=>
		!on_io || !io_hidden) else $error("hidden menu reached");
	AST_VIEW_TOGGLE: assert property (state_q == RSHD_DATA && term_item && press.up && !press.prog
		|=> hex_q != $past(hex_q)) else $error("view did not toggle");
	AST_BACK_OUT: assert property (state_q == RSHD_DATA && press.prog
		|=> state_q == RSHD_LIST ##0 (!press.prog)[*1]) else $error("program key not back to list");
	AST_HIGH_DIGIT: assert property (state_q == RSHD_RUN && $stable(status_q) && $past(status_q[15:12]) == 4'hA
		|=> display_digit_high_o == 7'h77) else $error("high digit not A");
	COV_STATUS_SHOWN: cover property (state_q == RSHD_DATA && menu_q == 3'h3 && item_q == 5'h07);
	COV_HEX_VIEW: cover property (show_term && hex_q);
	COV_BACK_TO_MENU: cover property (state_q == RSHD_LIST && press.prog ##1 state_q == RSHD_MENU);
endmodule

// [hw/rshd_regs.svh]
// bit positions, menu numbers, glyph codes and reset values of the status display
`ifndef RSHD_REGS_SVH
`define RSHD_REGS_SVH
// ***********************************
// status word bit positions
// ***********************************
`define RSHD_BIT_FWD 0
`define RSHD_BIT_REV 1
`define RSHD_BIT_DCB 2
`define RSHD_BIT_OFF 3
`define RSHD_BIT_BRK 4
`define RSHD_BIT_BUS 5
`define RSHD_BIT_TQL 6
`define RSHD_BIT_VLT 7
`define RSHD_BIT_CUR 8
`define RSHD_BIT_RUP 9
`define RSHD_BIT_RDN 10
`define RSHD_BIT_FLT 11
`define RSHD_BIT_LNK 12
`define RSHD_BIT_RSV_LO 13
`define RSHD_BIT_RSV_HI 14
`define RSHD_BIT_BSY 15
`define RSHD_STATUS_RST 16'h0000
// ***********************************
// menu and item numbers
// ***********************************
`define RSHD_SCOPE_FULL 2'h2
`define RSHD_MENU_MON 3'h3
`define RSHD_MENU_IO 3'h4
`define RSHD_MENU_RST 3'h0
`define RSHD_ITEM_RST 5'h00
`define RSHD_ITEM_STATUS 5'h07
`define RSHD_ITEM_TERM 5'h00
`define RSHD_ITEM_LINK 5'h01
// ***********************************
// glyph codes and segment patterns
// ***********************************
`define RSHD_GLY_DASH 5'h10
`define RSHD_GLY_BLANK 5'h11
`define RSHD_SEG_DASH 7'h40
`define RSHD_SEG_OFF 7'h00
`endif

// [hw/rshd_pkg.sv]
// types shared by the running status display
package rshd_pkg;
	typedef struct packed {
		logic write_busy;
		logic link_command_enable_flag;
		logic fault_active_flag;
		logic ramp_down_flag;
		logic ramp_up_flag;
		logic current_limit_flag;
		logic voltage_limit_flag;
		logic torque_limit_flag;
		logic bus_voltage_ok_flag;
		logic braking_flag;
		logic output_off_flag;
		logic dc_injection_flag;
		logic reverse_run_flag;
		logic forward_run_flag;
	} rshd_flags_type;
	typedef struct packed {
		logic enter;
		logic up;
		logic down;
		logic prog;
	} rshd_keys_type;
	typedef enum logic [1:0] {
		RSHD_RUN,
		RSHD_MENU,
		RSHD_LIST,
		RSHD_DATA
	} rshd_state_type;
	typedef logic [4:0] rshd_glyph_type;
endpackage

// [hw/rshd_key_sync.sv]
// keypad pin synchroniser with one-cycle press pulses
`timescale 1ns/1ps
module rshd_key_sync (
	input wire logic clk_i,
	input wire logic resetn_i,
	input rshd_pkg::rshd_keys_type keys_i,
	output rshd_pkg::rshd_keys_type press_o
);
	import rshd_pkg::*;
	logic [3:0] meta_q;
	logic [3:0] sync_q;
	logic [3:0] last_q;
	logic [3:0] press_q;
	logic [3:0] pins;
	assign pins = keys_i;
	genvar k;
	generate
		for (k = 0; k < 4; k++) begin : g_key
			// edge taken after the second stage, never from the first
			always_ff @(posedge clk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					meta_q[k] <= 1'b0;
					sync_q[k] <= 1'b0;
					last_q[k] <= 1'b0;
					press_q[k] <= 1'b0;
				end else begin
					meta_q[k] <= pins[k];
					sync_q[k] <= meta_q[k];
					last_q[k] <= sync_q[k];
					press_q[k] <= sync_q[k] & ~last_q[k];
				end
			end
		end
	endgenerate
	assign press_o = press_q;
endmodule

// [hw/rshd_seg_decode.sv]
// nibble or special code to seven-segment pattern, gfedcba order
`timescale 1ns/1ps
`include "rshd_regs.svh"
module rshd_seg_decode (
	input rshd_pkg::rshd_glyph_type glyph_i,
	output logic [6:0] seg_o
);
	import rshd_pkg::*;
	always_comb begin
		case (glyph_i)
			5'h00: seg_o = 7'h3F;
			5'h01: seg_o = 7'h06;
			5'h02: seg_o = 7'h5B;
			5'h03: seg_o = 7'h4F;
			5'h04: seg_o = 7'h66;
			5'h05: seg_o = 7'h6D;
			5'h06: seg_o = 7'h7D;
			5'h07: seg_o = 7'h07;
			5'h08: seg_o = 7'h7F;
			5'h09: seg_o = 7'h6F;
			5'h0A: seg_o = 7'h77;
			5'h0B: seg_o = 7'h7C;
			5'h0C: seg_o = 7'h39;
			5'h0D: seg_o = 7'h5E;
			5'h0E: seg_o = 7'h79;
			5'h0F: seg_o = 7'h71;
			`RSHD_GLY_DASH: seg_o = `RSHD_SEG_DASH;
			default: seg_o = `RSHD_SEG_OFF;
		endcase
	end
endmodule

// [tb/rshd_panel_model.sv]
// keypad and four-digit monitor model for the status display bench
`timescale 1ns/1ps
module rshd_panel_model #(
	parameter int HOLD_CYCLES = 6
) (
	input wire logic clk_i,
	input wire logic [6:0] digit_high_i,
	input wire logic [6:0] digit_upper_mid_i,
	input wire logic [6:0] digit_lower_mid_i,
	input wire logic [6:0] digit_low_i,
	output rshd_pkg::rshd_keys_type keys_o,
	output logic [15:0] shown_word_o,
	output logic shown_hex_o
);
	import rshd_pkg::*;
	// ***********************************
	// monitor reading
	// ***********************************
	logic [6:0] glyph_tab [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07,
		7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
	logic [4:0] rd_h, rd_u, rd_l, rd_w;
	// anything not a hex glyph reads as code 0x10, so dashes never pass as digits
	function automatic logic [4:0] read_glyph(input logic [6:0] seg);
		read_glyph = 5'h10;
		for (int n = 0; n < 16; n++) begin
			if (glyph_tab[n] === seg) begin
				read_glyph = {1'b0, 4'(n)};
			end
		end
	endfunction
	always_comb begin
		rd_h = read_glyph(digit_high_i);
		rd_u = read_glyph(digit_upper_mid_i);
		rd_l = read_glyph(digit_lower_mid_i);
		rd_w = read_glyph(digit_low_i);
		shown_word_o = {rd_h[3:0], rd_u[3:0], rd_l[3:0], rd_w[3:0]};
		shown_hex_o = !(rd_h[4] | rd_u[4] | rd_l[4] | rd_w[4]);
	end
	// ***********************************
	// keypad
	// ***********************************
	initial keys_o = '0;
	// release long enough for the synchroniser to see the key low again
	task automatic press(input logic [3:0] which);
		@(posedge clk_i);
		keys_o <= which;
		repeat (HOLD_CYCLES) @(posedge clk_i);
		keys_o <= 4'h0;
		repeat (4) @(posedge clk_i);
	endtask
endmodule

// [tb/rshd_status_display_tb.sv]
// self-checking bench for the running status display
`timescale 1ns/1ps
module rshd_status_display_tb;
	import rshd_pkg::*;
	logic clk_i, resetn_i, programming_mode_o, hex_view_o, shown_hex;
	rshd_flags_type flags_i;
	rshd_keys_type keys_i;
	logic [1:0] menu_scope_setting_i;
	logic [15:0] io_terminal_i, io_link_terminal_i, status_word_o, shown_word;
	logic [6:0] dig_h, dig_u, dig_l, dig_w;
	int n_mismatch, total_checks;
	localparam logic [3:0] K_ENTER = 4'h8, K_UP = 4'h4, K_DOWN = 4'h2, K_PROG = 4'h1;
	logic [15:0] word_tab [5] = '{16'h8ABC, 16'h1DE4, 16'h0123, 16'h1302, 16'hFFFF};
	rshd_status_display rshd_status_display_inst (.clk_i(clk_i), .resetn_i(resetn_i),
		.flags_i(flags_i), .keys_i(keys_i), .menu_scope_setting_i(menu_scope_setting_i),
		.io_terminal_i(io_terminal_i), .io_link_terminal_i(io_link_terminal_i),
		.status_word_o(status_word_o), .display_digit_high_o(dig_h),
		.display_digit_upper_mid_o(dig_u), .display_digit_lower_mid_o(dig_l),
		.display_digit_low_o(dig_w), .programming_mode_o(programming_mode_o),
		.hex_view_o(hex_view_o));
	rshd_panel_model #(.HOLD_CYCLES(6)) rshd_panel_model_inst (.clk_i(clk_i),
		.digit_high_i(dig_h), .digit_upper_mid_i(dig_u), .digit_lower_mid_i(dig_l),
		.digit_low_i(dig_w), .keys_o(keys_i), .shown_word_o(shown_word),
		.shown_hex_o(shown_hex));
	always #50 clk_i = ~clk_i;
	// ***********************************
	// compare and report
	// ***********************************
	task automatic note(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
		note(what, exp, got);
	endtask
	task automatic chk_seg(input string what, input logic [6:0] exp, input logic [6:0] got);
		note(what, {9'h000, exp}, {9'h000, got});
	endtask
	task automatic chk_bit(input string what, input logic exp, input logic got);
		note(what, {15'h0000, exp}, {15'h0000, got});
	endtask
	task automatic complete_run();
		$display("mismatches %0d, checks %0d", n_mismatch, total_checks);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// ***********************************
	// stimulus helpers
	// ***********************************
	task automatic settle(input int n);
		repeat (n) @(posedge clk_i);
		@(negedge clk_i);
	endtask
	// word and digits lag flags by one and two edges
	task automatic check_word(input logic [15:0] w);
		logic [15:0] want;
		want = {w[15], 2'b00, w[12:1], w[0] & ~w[1]};
		@(posedge clk_i);
		flags_i <= {w[15], w[12:0]};
		settle(3);
		chk_word("status word", want, status_word_o);
		chk_word("shown hex", want, shown_word);
		chk_bit("shown as hex", 1'b1, shown_hex);
	endtask
	task automatic key(input logic [3:0] k, input int n);
		repeat (n) rshd_panel_model_inst.press(k);
		@(negedge clk_i);
	endtask
	task automatic wait_mode(input logic want);
		int t;
		t = 0;
		while (programming_mode_o !== want && t < 20) begin
			@(negedge clk_i);
			t++;
		end
		chk_bit("programming mode", want, programming_mode_o);
		if (t >= 20) begin
			complete_run();
		end
	endtask
	task automatic set_io(input logic [15:0] a, input logic [15:0] b);
		@(posedge clk_i);
		io_terminal_i <= a;
		io_link_terminal_i <= b;
		settle(3);
	endtask
	// ***********************************
	// main sequence
	// ***********************************
	initial begin
		clk_i = 1'b0;
		resetn_i = 1'b0;
		flags_i = '0;
		menu_scope_setting_i = 2'h0;
		io_terminal_i = 16'h0000;
		io_link_terminal_i = 16'h0000;
		n_mismatch = 0;
		total_checks = 0;
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		chk_word("status in reset", 16'h0000, status_word_o);
		chk_seg("digit in reset", 7'h00, dig_h);
		chk_bit("mode in reset", 1'b0, programming_mode_o);
		@(posedge clk_i);
		resetn_i <= 1'b1;
		for (int i = 0; i < 14; i++) begin
			check_word(i == 13 ? 16'h8000 : 16'h0001 << i);
		end
		foreach (word_tab[j]) begin
			check_word(word_tab[j]);
		end
		key(K_ENTER, 1);
		wait_mode(1'b1);
		chk_seg("menu digit", 7'h3F, dig_h);
		key(K_UP, 3);
		key(K_ENTER, 1);
		key(K_UP, 7);
		key(K_ENTER, 1);
		chk_word("monitor data", 16'h9FFE, shown_word);
		key(K_PROG, 1);
		chk_seg("list item", 7'h07, dig_w);
		chk_seg("list dash", 7'h40, dig_u);
		key(K_PROG, 1);
		chk_seg("menu number", 7'h4F, dig_h);
		chk_seg("menu dash", 7'h40, dig_l);
		key(K_PROG, 1);
		wait_mode(1'b0);
		// scope 0: stepping up from menu 0 must jump over menu 4
		key(K_ENTER, 1);
		key(K_UP, 4);
		chk_seg("menu hidden", 7'h6D, dig_h);
		key(K_PROG, 1);
		menu_scope_setting_i <= 2'h2;
		key(K_ENTER, 1);
		key(K_UP, 4);
		chk_seg("menu offered", 7'h66, dig_h);
		key(K_ENTER, 2);
		chk_bit("segment view", 1'b0, hex_view_o);
		chk_seg("all open", 7'h40, dig_w);
		set_io(16'h5A3C, 16'hC0DE);
		chk_seg("segment high", 7'h05, dig_h);
		chk_seg("segment low", 7'h0C, dig_w);
		key(K_UP, 1);
		chk_bit("hex view on", 1'b1, hex_view_o);
		chk_word("terminal hex", 16'h5A3C, shown_word);
		key(K_DOWN, 1);
		chk_bit("hex view off", 1'b0, hex_view_o);
		key(K_PROG, 1);
		key(K_UP, 1);
		key(K_ENTER, 1);
		key(K_DOWN, 1);
		chk_word("link terminal hex", 16'hC0DE, shown_word);
		key(K_PROG, 3);
		wait_mode(1'b0);
		complete_run();
	end
endmodule
